// ==== core/gpt_defs.svh ====
// constants for the general purpose timer set
`ifndef GPT_DEFS_SVH
`define GPT_DEFS_SVH
`define GPT_NUM_TMR 4
`define GPT_CNT_W 16
`define GPT_PRE_W 12
`define GPT_FULL_SCALE 16'hffff
`define GPT_ZERO 16'h0000
`define GPT_ONE 16'h0001
`define GPT_OFF_LOAD 4'h0
`define GPT_OFF_VAL 4'h4
`define GPT_OFF_CTRL 4'h8
`define GPT_OFF_STAT 8'h40
`define GPT_OFF_MASK 8'h44
`define GPT_RST_LOAD 16'h0000
`define GPT_RST_CTRL 8'h00
`define GPT_RST_FLAGS 4'h0
`define GPT_PRE_DIV1 12'h000
`define GPT_PRE_DIV16 12'h00f
`define GPT_PRE_DIV256 12'h0ff
`define GPT_PRE_DIV4096 12'hfff
`endif

// ==== core/gpt_pkg.sv ====
// types shared by the timer set
`include "gpt_defs.svh"
package gpt_pkg;
    typedef enum logic [1:0] {gpt_pre_1, gpt_pre_16, gpt_pre_256, gpt_pre_4096} gpt_pre_e;
    typedef struct packed {
        logic [1:0] rsvd;
        logic src_ext;
        gpt_pre_e pre;
        logic periodic;
        logic up;
        logic en;
    } gpt_ctrl_s;
    typedef logic [`GPT_CNT_W-1:0] gpt_cnt_t;
endpackage

// ==== core/gpt_tmr_if.sv ====
// link between the register block and one timer/counter
`timescale 1ns/100ps
`default_nettype none
interface gpt_tmr_if;
    gpt_pkg::gpt_ctrl_s ctrl;
    gpt_pkg::gpt_cnt_t load;
    logic start;
    logic ext_tick;
    gpt_pkg::gpt_cnt_t count;
    logic tout;
    modport ctl (output ctrl, output load, output start, output ext_tick,
                 input count, input tout);
    modport tmr (input ctrl, input load, input start, input ext_tick,
                 output count, output tout);
endinterface
`default_nettype wire

// ==== core/gpt_sync.sv ====
// three stage pin synchroniser with rising edge pulse
`timescale 1ns/100ps
`default_nettype none
module gpt_sync (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic pin_in,
    output logic rise
);
    typedef struct packed {
        logic s1;
        logic s2;
        logic s3;
        logic lvl;
        logic rise;
    } gpt_sync_s;
    gpt_sync_s st_r;
    gpt_sync_s st_nxt;
    always_comb begin
        st_nxt = st_r;
        st_nxt.s1 = pin_in;
        st_nxt.s2 = st_r.s1;
        st_nxt.s3 = st_r.s2;
        st_nxt.rise = 1'b0;
        if (st_r.s2 == st_r.s3 && st_r.s2 != st_r.lvl) begin
            st_nxt.lvl = st_r.s2;
            st_nxt.rise = st_r.s2;
        end
    end
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end
    assign rise = st_r.rise;
endmodule
`default_nettype wire

// ==== core/gpt_timer.sv ====
// one timer/counter with prescaler, free running or periodic
`timescale 1ns/100ps
`default_nettype none
`include "gpt_defs.svh"
module gpt_timer (
    input wire logic clk,
    input wire logic sys_rst,
    gpt_tmr_if.tmr bus
);
    typedef struct packed {
        gpt_pkg::gpt_cnt_t cnt;
        logic [`GPT_PRE_W-1:0] pre;
        logic run;
        logic tout;
    } gpt_tmr_s;
    gpt_tmr_s st_r;
    gpt_tmr_s st_nxt;
    logic [`GPT_PRE_W-1:0] ratio;
    logic src_tick;
    logic step;
    always_comb begin
        unique case (bus.ctrl.pre)
            gpt_pkg::gpt_pre_1: ratio = `GPT_PRE_DIV1;
            gpt_pkg::gpt_pre_16: ratio = `GPT_PRE_DIV16;
            gpt_pkg::gpt_pre_256: ratio = `GPT_PRE_DIV256;
            gpt_pkg::gpt_pre_4096: ratio = `GPT_PRE_DIV4096;
        endcase
    end
    assign src_tick = bus.ctrl.src_ext ? bus.ext_tick : 1'b1;
    assign step = st_r.run && src_tick && st_r.pre == ratio;
    always_comb begin
        st_nxt = st_r;
        st_nxt.tout = 1'b0;
        if (bus.start) begin
            // control write restarts from load or range end
            st_nxt.pre = '0;
            st_nxt.run = bus.ctrl.en;
            if (bus.ctrl.periodic) begin
                st_nxt.cnt = bus.load;
            end else begin
                st_nxt.cnt = bus.ctrl.up ? `GPT_ZERO : `GPT_FULL_SCALE;
            end
        end else if (step) begin
            st_nxt.pre = '0;
            if (bus.ctrl.up) begin
                if (st_r.cnt == `GPT_FULL_SCALE) begin
                    // wrap or reload
                    st_nxt.cnt = bus.ctrl.periodic ? bus.load + `GPT_ONE : `GPT_ZERO;
                end else begin
                    st_nxt.cnt = st_r.cnt + `GPT_ONE;
                end
                st_nxt.tout = st_nxt.cnt == `GPT_FULL_SCALE;
            end else begin
                if (st_r.cnt == `GPT_ZERO) begin
                    // wrap or reload
                    st_nxt.cnt = bus.ctrl.periodic ? bus.load - `GPT_ONE : `GPT_FULL_SCALE;
                end else begin
                    st_nxt.cnt = st_r.cnt - `GPT_ONE;
                end
                st_nxt.tout = st_nxt.cnt == `GPT_ZERO;
            end
        end else if (st_r.run && src_tick) begin
            st_nxt.pre = st_r.pre + 12'h001;
        end
    end
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end
    assign bus.count = st_r.cnt;
    assign bus.tout = st_r.tout;

    a_down_wrap: assert property (@(posedge clk) disable iff (sys_rst)
        step && !bus.start && !bus.ctrl.up && !bus.ctrl.periodic && st_r.cnt == `GPT_ZERO
        |=> st_r.cnt == `GPT_FULL_SCALE)
        else $error("free down count did not wrap to full scale");
    a_up_wrap: assert property (@(posedge clk) disable iff (sys_rst)
        step && !bus.start && bus.ctrl.up && !bus.ctrl.periodic && st_r.cnt == `GPT_FULL_SCALE
        |=> st_r.cnt == `GPT_ZERO)
        else $error("free up count did not wrap to zero");
    a_period_reload: assert property (@(posedge clk) disable iff (sys_rst)
        step && !bus.start && bus.ctrl.periodic && !bus.ctrl.up && st_r.cnt == `GPT_ZERO
        |=> st_r.cnt == $past(bus.load) - `GPT_ONE
            && st_r.tout == ($past(bus.load) == `GPT_ONE))
        else $error("periodic down count did not reload");
    a_down_step: assert property (@(posedge clk) disable iff (sys_rst)
        step && !bus.start && !bus.ctrl.up && st_r.cnt != `GPT_ZERO
        |=> st_r.cnt == $past(st_r.cnt) - `GPT_ONE)
        else $error("down step not by one");
    a_hold_prescale: assert property (@(posedge clk) disable iff (sys_rst)
        st_r.run && !bus.start && !step |=> st_r.cnt == $past(st_r.cnt))
        else $error("count moved between prescaler steps");
    a_start_load: assert property (@(posedge clk) disable iff (sys_rst)
        bus.start && bus.ctrl.periodic |=> st_r.cnt == $past(bus.load) && st_r.run == $past(bus.ctrl.en))
        else $error("start did not load the reload value");
    c_timeout: cover property (@(posedge clk) disable iff (sys_rst) st_r.tout);
    c_ext_step: cover property (@(posedge clk) disable iff (sys_rst) step && bus.ctrl.src_ext);
endmodule
`default_nettype wire

// ==== core/gpt_top.sv ====
// four timer/counters with an avalon-mm register slave and interrupt
// Behaviour
// - four independent timers
// - each timer runs free-running or periodic
// - free down count wraps zero to maximum
// - free up count wraps full scale to zero
// - periodic count restarts one step past reload value (load - 1 down, load + 1 up)
// - down period is load times prescale over source
// - up period is full scale minus load, scaled
// - live count readable anytime without disturbing it
// - control register write starts the timer
`timescale 1ns/100ps
`default_nettype none
`include "gpt_defs.svh"
module gpt_top (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic [7:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    input wire logic [`GPT_NUM_TMR-1:0] ext_clk_pin,
    output logic irq
);
    typedef struct packed {
        logic waitreq;
        logic [31:0] rdata;
        logic irq;
        logic [`GPT_NUM_TMR-1:0] status;
        logic [`GPT_NUM_TMR-1:0] mask;
        logic [`GPT_NUM_TMR-1:0] start;
        gpt_pkg::gpt_cnt_t [`GPT_NUM_TMR-1:0] load;
        gpt_pkg::gpt_ctrl_s [`GPT_NUM_TMR-1:0] ctrl;
    } gpt_top_s;

    gpt_top_s st_r;
    gpt_top_s st_nxt;
    logic [`GPT_NUM_TMR-1:0] ext_rise;
    logic [`GPT_NUM_TMR-1:0] tout;
    gpt_pkg::gpt_cnt_t count [`GPT_NUM_TMR];
    logic req;
    logic acc;
    logic tmr_sel;
    logic [1:0] idx;
    logic [3:0] off;

    gpt_tmr_if tif[`GPT_NUM_TMR]();

    // one timer, synchroniser and link per instance
    for (genvar g = 0; g < `GPT_NUM_TMR; g++) begin : g_tmr
        // external source passes four flops (three synchroniser stages and the pulse) before counting
        gpt_sync u_sync (
            .clk(clk),
            .sys_rst(sys_rst),
            .pin_in(ext_clk_pin[g]),
            .rise(ext_rise[g])
        );
        gpt_timer u_timer (
            .clk(clk),
            .sys_rst(sys_rst),
            .bus(tif[g])
        );
        assign tif[g].ctrl = st_r.ctrl[g];
        assign tif[g].load = st_r.load[g];
        assign tif[g].start = st_r.start[g];
        assign tif[g].ext_tick = ext_rise[g];
        assign tout[g] = tif[g].tout;
        assign count[g] = tif[g].count;
    end

    assign req = avs_read || avs_write;
    assign acc = req && !st_r.waitreq;
    assign tmr_sel = avs_address[7:6] == 2'b00;
    assign idx = avs_address[5:4];
    assign off = avs_address[3:0];

    // byte lane merge for a register of up to 32 bits
    function automatic logic [31:0] gpt_merge(input logic [31:0] old_v,
                                              input logic [31:0] new_v,
                                              input logic [3:0] be);
        logic [31:0] res;
        res = old_v;
        for (int b = 0; b < 4; b++) begin
            if (be[b]) begin
                res[b*8 +: 8] = new_v[b*8 +: 8];
            end
        end
        return res;
    endfunction

    // read data for the addressed register, zero when unmapped
    function automatic logic [31:0] gpt_rd_mux(input gpt_top_s s,
                                               input logic [7:0] addr,
                                               input gpt_pkg::gpt_cnt_t c0,
                                               input gpt_pkg::gpt_cnt_t c1,
                                               input gpt_pkg::gpt_cnt_t c2,
                                               input gpt_pkg::gpt_cnt_t c3);
        logic [31:0] v;
        gpt_pkg::gpt_cnt_t cv;
        v = 32'h0000_0000;
        unique case (addr[5:4])
            2'h0: cv = c0;
            2'h1: cv = c1;
            2'h2: cv = c2;
            2'h3: cv = c3;
        endcase
        if (addr[7:6] == 2'b00) begin
            if (addr[3:0] == `GPT_OFF_LOAD) begin
                v[`GPT_CNT_W-1:0] = s.load[addr[5:4]];
            end else if (addr[3:0] == `GPT_OFF_VAL) begin
                // live count, read without touching the counter
                v[`GPT_CNT_W-1:0] = cv;
            end else if (addr[3:0] == `GPT_OFF_CTRL) begin
                v[7:0] = s.ctrl[addr[5:4]];
            end
        end else if (addr == `GPT_OFF_STAT) begin
            v[`GPT_NUM_TMR-1:0] = s.status;
        end else if (addr == `GPT_OFF_MASK) begin
            v[`GPT_NUM_TMR-1:0] = s.mask;
        end
        return v;
    endfunction

    always_comb begin
        logic [31:0] tmp;
        tmp = 32'h0000_0000;
        st_nxt = st_r;
        st_nxt.start = '0;
        // bus handshake: one wait cycle, then one cycle of acceptance
        if (acc) begin
            st_nxt.waitreq = 1'b1;
        end else if (req) begin
            st_nxt.waitreq = 1'b0;
            st_nxt.rdata = avs_read ? gpt_rd_mux(st_r, avs_address, count[0], count[1],
                                                 count[2], count[3]) : 32'h0000_0000;
        end
        if (acc && avs_write) begin
            if (tmr_sel && off == `GPT_OFF_LOAD) begin
                tmp = gpt_merge({16'h0000, st_r.load[idx]}, avs_writedata, avs_byteenable);
                st_nxt.load[idx] = tmp[`GPT_CNT_W-1:0];
            end else if (tmr_sel && off == `GPT_OFF_CTRL) begin
                tmp = gpt_merge({24'h00_0000, st_r.ctrl[idx]}, avs_writedata, avs_byteenable);
                // mode, direction, prescale, source, enable
                st_nxt.ctrl[idx] = tmp[7:0];
                st_nxt.ctrl[idx].rsvd = 2'b00;
                st_nxt.start[idx] = 1'b1;
            end else if (avs_address == `GPT_OFF_STAT && avs_byteenable[0]) begin
                st_nxt.status = st_r.status & ~avs_writedata[`GPT_NUM_TMR-1:0];
            end else if (avs_address == `GPT_OFF_MASK && avs_byteenable[0]) begin
                st_nxt.mask = avs_writedata[`GPT_NUM_TMR-1:0];
            end
        end
        // a timeout in the clearing cycle still sets its flag
        st_nxt.status = st_nxt.status | tout;
        st_nxt.irq = |(st_nxt.status & st_nxt.mask);
    end

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            st_r.waitreq <= 1'b1;
            st_r.rdata <= 32'h0000_0000;
            st_r.irq <= 1'b0;
            st_r.status <= `GPT_RST_FLAGS;
            st_r.mask <= `GPT_RST_FLAGS;
            st_r.start <= '0;
            st_r.load <= {`GPT_NUM_TMR{`GPT_RST_LOAD}};
            st_r.ctrl <= {`GPT_NUM_TMR{`GPT_RST_CTRL}};
        end else begin
            st_r <= st_nxt;
        end
    end

    assign avs_readdata = st_r.rdata;
    assign avs_waitrequest = st_r.waitreq;
    assign irq = st_r.irq;

    a_flag_sticky: assert property (@(posedge clk) disable iff (sys_rst)
        st_r.status[0] && !(acc && avs_write && avs_address == `GPT_OFF_STAT
                             && avs_byteenable[0] && avs_writedata[0])
        |=> st_r.status[0])
        else $error("timeout flag dropped without a clear");
    a_flag_set: assert property (@(posedge clk) disable iff (sys_rst)
        tout[1] |=> st_r.status[1])
        else $error("timeout did not set its flag");
    a_irq_level: assert property (@(posedge clk) disable iff (sys_rst)
        ##1 irq == |($past(st_nxt.status) & $past(st_nxt.mask)))
        else $error("interrupt does not follow unmasked flags");
    a_read_live: assert property (@(posedge clk) disable iff (sys_rst)
        avs_read && st_r.waitreq && avs_address == {2'b00, 2'h2, `GPT_OFF_VAL}
        |=> avs_readdata[15:0] == $past(count[2]) && avs_readdata[31:16] == 16'h0000)
        else $error("value read does not show the live count");
    a_wait_once: assert property (@(posedge clk) disable iff (sys_rst)
        req && st_r.waitreq |=> !avs_waitrequest ##1 avs_waitrequest)
        else $error("waitrequest not low for exactly one cycle");
    a_ctrl_start: assert property (@(posedge clk) disable iff (sys_rst)
        acc && avs_write && avs_address == {2'b00, 2'h3, `GPT_OFF_CTRL} && avs_byteenable[0]
        |=> st_r.start[3] && st_r.ctrl[3].en == $past(avs_writedata[0]) ##1 !st_r.start[3])
        else $error("control write did not start the timer once");
    a_four_tmr: assert property (@(posedge clk) disable iff (sys_rst)
        acc && avs_write && tmr_sel && off == `GPT_OFF_LOAD && avs_byteenable == 4'hf
        |=> st_r.load[$past(idx)] == $past(avs_writedata[15:0]))
        else $error("reload value not stored for the addressed timer");
    c_irq: cover property (@(posedge clk) disable iff (sys_rst) irq);
    c_clear: cover property (@(posedge clk) disable iff (sys_rst)
        st_r.status[0] ##[1:20] !st_r.status[0]);
    c_all_out: cover property (@(posedge clk) disable iff (sys_rst) &st_r.status);
endmodule
`default_nettype wire

// ==== test/gpt_tb.sv ====
// self-checking bench for the timer set
`timescale 1ns/100ps
`default_nettype none
`include "gpt_defs.svh"
module testbench;
    logic clk = 1'b0;
    logic sys_rst = 1'b1;
    logic [7:0] avs_address = 8'h00;
    logic avs_read = 1'b0;
    logic avs_write = 1'b0;
    logic [31:0] avs_writedata = 32'h0;
    logic [3:0] avs_byteenable = 4'hf;
    logic [31:0] avs_readdata;
    logic avs_waitrequest;
    logic [3:0] ext_clk_pin = 4'h0;
    logic irq;
    int mismatches = 0;
    int n_checks = 0;
    int cyc = 0;
    logic [31:0] rd;

    always #2 clk = ~clk;
    always @(posedge clk) cyc <= cyc + 1;

    gpt_top gpt_top_inst (.clk(clk), .sys_rst(sys_rst), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .ext_clk_pin(ext_clk_pin), .irq(irq));

    task automatic fail(input string m);
        mismatches++;
        $display("MISMATCH at %0t: %s", $time, m);
    endtask

    task automatic check(input logic [31:0] got, input logic [31:0] exp, input string m);
        n_checks++;
        if (got !== exp) begin
            fail($sformatf("%s got %h exp %h", m, got, exp));
        end
    endtask

    task automatic check_in(input logic [31:0] got, input int lo, input int hi, input string m);
        n_checks++;
        if (got === 32'hx || int'(got) < lo || int'(got) > hi) begin
            fail($sformatf("%s got %h", m, got));
        end
    endtask

    function automatic logic [7:0] ta(input int t, input logic [3:0] off);
        return {2'b00, t[1:0], off};
    endfunction

    // one transfer: hold until waitrequest sampled low, then release
    task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        avs_address <= a;
        avs_writedata <= d;
        avs_write <= wr;
        avs_read <= ~wr;
        do begin
            @(posedge clk);
            n++;
        end while (avs_waitrequest !== 1'b0 && n < 50);
        if (n >= 50) begin
            fail("bus hang");
        end
        rd = avs_readdata;
        avs_write <= 1'b0;
        avs_read <= 1'b0;
        @(posedge clk);
    endtask

    task automatic wait_rise(input int max);
        int n;
        logic last;
        last = irq;
        for (n = 0; n < max; n++) begin
            @(posedge clk);
            if (irq === 1'b1 && last === 1'b0) begin
                return;
            end
            last = irq;
        end
        fail("no irq rise");
    endtask

    task automatic test_reset;
        for (int t = 0; t < 4; t++) begin
            bus(0, ta(t, `GPT_OFF_LOAD), 0);
            check(rd, 32'h0, "load rst");
            bus(0, ta(t, `GPT_OFF_VAL), 0);
            check(rd, 32'h0, "count rst");
            bus(0, ta(t, `GPT_OFF_CTRL), 0);
            check(rd, 32'h0, "ctrl rst");
        end
        bus(0, `GPT_OFF_STAT, 0);
        check(rd, 32'h0, "stat rst");
        bus(0, `GPT_OFF_MASK, 0);
        check(rd, 32'h0, "mask rst");
        bus(1, 8'h4c, 32'hffffffff);
        bus(0, 8'h4c, 0);
        check(rd, 32'h0, "unmapped");
        check(irq, 1'b0, "irq rst");
        $display("test reset done");
    endtask

    // two timeouts apart by the period, then masked flag leaves irq low
    task automatic test_period(input int t, input logic [15:0] ld, input logic [7:0] c,
            input int exp);
        int t0;
        bus(1, `GPT_OFF_MASK, 32'h1 << t);
        bus(1, ta(t, `GPT_OFF_LOAD), {16'h0, ld});
        bus(0, ta(t, `GPT_OFF_LOAD), 0);
        check(rd, {16'h0, ld}, "load rb");
        bus(1, ta(t, `GPT_OFF_CTRL), {24'h0, c});
        wait_rise(exp + 20);
        t0 = cyc;
        bus(1, `GPT_OFF_STAT, 32'h1 << t);
        wait_rise(exp + 20);
        check(32'(cyc - t0), 32'(exp), "period");
        bus(1, `GPT_OFF_MASK, 0);
        bus(1, `GPT_OFF_STAT, 32'h1 << t);
        repeat (exp + 8) @(posedge clk);
        bus(0, `GPT_OFF_STAT, 0);
        check(rd, 32'h1 << t, "flag masked");
        check(irq, 1'b0, "irq masked");
        bus(1, ta(t, `GPT_OFF_CTRL), 0);
        bus(1, `GPT_OFF_STAT, 32'hf);
        $display("test period %0d done", t);
    endtask

    task automatic test_free_down;
        logic [31:0] r1;
        int t0;
        bus(1, `GPT_OFF_MASK, 32'h1);
        bus(1, ta(0, `GPT_OFF_CTRL), 32'h01);
        t0 = cyc;
        bus(0, ta(0, `GPT_OFF_VAL), 0);
        r1 = rd;
        check_in(r1, 16'hffe0, 16'hffff, "down start");
        bus(0, ta(0, `GPT_OFF_VAL), 0);
        check(r1 - rd, 32'h3, "down step");
        wait_rise(70000);
        check_in(32'(cyc - t0), 65530, 65545, "down wrap time");
        bus(0, ta(0, `GPT_OFF_VAL), 0);
        check_in(rd, 16'hff00, 16'hffff, "wrapped");
        repeat (20) @(posedge clk);
        bus(0, `GPT_OFF_STAT, 0);
        check(rd, 32'h1, "sticky");
        check(irq, 1'b1, "irq held");
        bus(1, `GPT_OFF_STAT, 32'h1);
        bus(0, `GPT_OFF_STAT, 0);
        check(rd, 32'h0, "cleared");
        check(irq, 1'b0, "irq cleared");
        bus(1, ta(0, `GPT_OFF_CTRL), 0);
        $display("test free down done");
    endtask

    task automatic test_free_up;
        logic [31:0] r1;
        bus(1, ta(1, `GPT_OFF_CTRL), 32'h03);
        bus(0, ta(1, `GPT_OFF_VAL), 0);
        r1 = rd;
        check_in(r1, 0, 16'h0020, "up start");
        bus(0, ta(1, `GPT_OFF_VAL), 0);
        check(rd - r1, 32'h3, "up step");
        bus(1, ta(1, `GPT_OFF_CTRL), 0);
        $display("test free up done");
    endtask

    // external source ticks on rising pin edges only; a control write with enable low restarts at full scale and stops
    task automatic test_ext;
        logic [31:0] r1;
        bus(1, ta(2, `GPT_OFF_CTRL), 32'h21);
        repeat (5) begin
            ext_clk_pin <= 4'h4;
            repeat (4) @(posedge clk);
            ext_clk_pin <= 4'h0;
            repeat (4) @(posedge clk);
        end
        repeat (8) @(posedge clk);
        bus(0, ta(2, `GPT_OFF_VAL), 0);
        r1 = rd;
        bus(0, ta(2, `GPT_OFF_VAL), 0);
        check(rd, r1, "ext stable");
        check(rd, 32'h0000fffa, "ext count");
        bus(1, ta(2, `GPT_OFF_CTRL), 0);
        repeat (10) @(posedge clk);
        bus(0, ta(2, `GPT_OFF_VAL), 0);
        check(rd, 32'h0000ffff, "stopped");
        bus(1, ta(3, `GPT_OFF_CTRL), 32'hff);
        bus(0, ta(3, `GPT_OFF_CTRL), 0);
        check(rd, 32'h3f, "ctrl rsvd");
        bus(1, ta(3, `GPT_OFF_CTRL), 0);
        $display("test ext done");
    endtask

    task automatic tally_and_finish;
        $display("checks %0d mismatches %0d", n_checks, mismatches);
        if (mismatches == 0 && n_checks > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    initial begin
        repeat (95000) @(posedge clk);
        fail("watchdog");
        tally_and_finish();
    end

    initial begin
        repeat (20) @(posedge clk);
        sys_rst <= 1'b0;
        @(posedge clk);
        test_reset();
        test_period(1, 16'h000a, 8'h0d, 160);
        test_period(2, 16'hfff0, 8'h07, 15);
        test_period(3, 16'h0002, 8'h15, 512);
        test_period(0, 16'h0001, 8'h1d, 4096);
        test_free_up();
        test_ext();
        test_free_down();
        tally_and_finish();
    end
endmodule
`default_nettype wire
